// File: common/arc_pkg.sv
// Shared constants, field layouts and rate-code helpers for the rate converter control
package arc_pkg;

  // ----------------------------------------------------------------
  // Device register map (16-bit data)
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_PATH_EN   = 16'h0ee0;
  localparam logic [15:0] REG_PATH_STS  = 16'h0ee1;
  localparam logic [15:0] REG_RATE_A    = 16'h0ee2;
  localparam logic [15:0] REG_RATE_B    = 16'h0ee3;
  localparam logic [15:0] REG_SRC_BASE  = 16'h0a80;
  localparam logic [15:0] REG_SRC_LAST  = 16'h0a98;
  localparam int          SRC_STEP_LSB  = 3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          EN_FWD_R      = 0;
  localparam int          EN_FWD_L      = 1;
  localparam int          EN_REV_R      = 2;
  localparam int          EN_REV_L      = 3;
  localparam int          RATE_LSB      = 11;
  localparam int          RATE_MSB      = 15;
  localparam logic [3:0]  EN_RST        = 4'h0;
  localparam logic [4:0]  RATE_A_RST    = 5'h00;
  localparam logic [4:0]  RATE_B_RST    = 5'h08;
  localparam logic [7:0]  SRC_RST       = 8'h00;

  // ----------------------------------------------------------------
  // Rate codes
  // ----------------------------------------------------------------
  localparam logic [4:0]  RATE_SYS_1    = 5'h00;
  localparam logic [4:0]  RATE_SYS_3    = 5'h02;
  localparam logic [4:0]  RATE_SEC_1    = 5'h08;
  localparam logic [4:0]  RATE_SEC_2    = 5'h09;
  localparam int          RATE_DOM_BIT  = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          LOCK_TIME_NS  = 100_000;
  localparam int          SRC_WAIT_NS   = 125_000;
  localparam int          CNT_W         = 12;
  localparam logic [11:0] LOCK_CYC      = 12'(LOCK_TIME_NS / CLK_PERIOD_NS);
  localparam logic [11:0] SRC_WAIT_CYC  = 12'((SRC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Controller register map (AXI4-Lite byte offsets) and limits
  // ----------------------------------------------------------------
  localparam logic [5:0]  CTL_ENABLE    = 6'h00;
  localparam logic [5:0]  CTL_RATE_A    = 6'h04;
  localparam logic [5:0]  CTL_RATE_B    = 6'h08;
  localparam logic [5:0]  CTL_SRC       = 6'h0c;
  localparam logic [5:0]  CTL_KHZ       = 6'h10;
  localparam logic [5:0]  CTL_STATUS    = 6'h14;
  localparam int          CTL_ERR_BIT   = 4;
  localparam logic [8:0]  KHZ_MIN       = 9'h008;
  localparam logic [8:0]  KHZ_MAX       = 9'h0c0;
  localparam logic [2:0]  RATIO_MAX     = 3'h6;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  function automatic logic arc_rate_valid(input logic [4:0] code);
    return (code <= RATE_SYS_3) || (code == RATE_SEC_1) || (code == RATE_SEC_2);
  endfunction

  // 0 = system domain, 1 = secondary domain
  function automatic logic arc_rate_dom(input logic [4:0] code);
    return code[RATE_DOM_BIT];
  endfunction

endpackage

// File: common/arc_link_if.sv
// Register link between the converter control (device) and its configuring controller
`timescale 1ns/100ps
interface arc_link_if (
  input wire logic aclk,   // Shared clock
  input wire logic aresetn // Shared synchronous reset, active low
);
  logic        req;   // Access request, held until ack
  logic        we;    // 1 = write, 0 = read
  logic [15:0] addr;  // Device register address
  logic [15:0] wdata; // Write data
  logic        ack;   // One-cycle completion pulse
  logic [15:0] rdata; // Read data, valid with ack

  modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
  modport ctl (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// File: hw/arc_dev.sv
// Converter control: rate selectors, path enables, clock check, status and lock
//
// Contract
// - each rate runs on exactly one domain
// - stereo two-way paths, rates pick domains independently
// - rate A sets forward inputs, reverse outputs
// - rate B sets reverse inputs, forward outputs
// - both rates may share one domain
// - software keeps rates within 8 to 192 kHz
// - software keeps sync/async rate ratio at most 6
// - clear sources before changing a rate selector
// - wait 125 us after clearing sources
// - bits 1 and 0 enable forward left/right
// - bits 3 and 2 enable reverse; reset disabled
// - per-path lock, low after change, to interrupts
// - lock can drive a general-purpose pin
// - refuse enable when domain clock too slow
// - refused enable leaves running paths alone
// - read-only status shows paths actually running
// - source selections live at 0x0A80 to 0x0A98
// - sources must match converter side rate
// - rate code set with reserved codes
// - rate B in bits 15:11, resets async one
// - status bits mirror the enable layout
`timescale 1ns/100ps
module arc_dev
  import arc_pkg::*;
(
  input  wire logic            aclk,          // System clock, 20 MHz
  input  wire logic            aresetn,       // Synchronous reset, active low
  arc_link_if.dev              link,          // Register access port
  input  wire logic            sys_clk_ok,    // System domain clock fast enough (async)
  input  wire logic            sec_clk_ok,    // Secondary domain clock fast enough (async)
  input  wire logic [1:0]      gpio_lock_sel, // Path whose lock drives the pin
  output logic      [3:0]      path_run,      // Paths actually running
  output logic      [3:0]      path_lock,     // Per-path lock, to interrupt controller
  output logic                 lock_gpio,     // Selected lock for a general-purpose pin
  output logic      [4:0]      rate_a_sel,    // Rate A code
  output logic      [4:0]      rate_b_sel,    // Rate B code
  output logic                 rate_a_dom,    // Rate A domain, 1 = secondary
  output logic                 rate_b_dom,    // Rate B domain, 1 = secondary
  output logic      [3:0][7:0] path_src       // Input source selection per path
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  ack;
    logic [15:0]           rdata;
    logic [3:0]            en;
    logic [3:0]            sts;
    logic [4:0]            rate_a;
    logic [4:0]            rate_b;
    logic [3:0][7:0]       src;
    // Clock-ok pins pass two flops; ok_prev only feeds the edge detect
    logic [1:0]            ok_s1;
    logic [1:0]            ok_s2;
    logic [1:0]            ok_prev;
    logic [3:0][CNT_W-1:0] lock_cnt;
    logic [3:0]            lock;
    logic                  lock_pin;
  } arc_dev_s;

  arc_dev_s r;
  arc_dev_s next_r;

  // Returns {hit, path index} for a source selection address
  function automatic logic [2:0] src_slot(input logic [15:0] a);
    logic [15:0] off;
    off = a - REG_SRC_BASE;
    return {(a >= REG_SRC_BASE) && (a <= REG_SRC_LAST) && (off[SRC_STEP_LSB-1:0] == 3'h0),
            off[SRC_STEP_LSB+1:SRC_STEP_LSB]};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       ck_ok;
    logic       rate_chg;
    logic       ref_chg;
    logic [1:0] clk_chg;
    logic [2:0] slot;
    next_r   = r;
    ck_ok    = 1'b0;
    rate_chg = 1'b0;
    ref_chg  = 1'b0;
    clk_chg  = 2'b00;
    slot     = src_slot(link.addr);

    next_r.ack     = 1'b0;
    next_r.ok_s1   = {sec_clk_ok, sys_clk_ok};
    next_r.ok_s2   = r.ok_s1;
    next_r.ok_prev = r.ok_s2;

    // Every path touches both rates, so both referenced domains must pass
    ck_ok = arc_rate_valid(r.rate_a) && arc_rate_valid(r.rate_b)
            && r.ok_s2[arc_rate_dom(r.rate_a)] && r.ok_s2[arc_rate_dom(r.rate_b)];
    clk_chg = r.ok_s2 ^ r.ok_prev;
    ref_chg = clk_chg[arc_rate_dom(r.rate_a)] | clk_chg[arc_rate_dom(r.rate_b)];

    // One access per request; ack drops for a cycle so a held req is not retaken
    if (link.req && !r.ack)
    begin
      next_r.ack = 1'b1;
      if (link.we)
      begin
        if (link.addr == REG_PATH_EN)
        begin
          next_r.en = link.wdata[3:0];
          for (int i = 0; i < 4; i++)
          begin
            if (!link.wdata[i])
              next_r.sts[i] = 1'b0;
            else if (!r.sts[i])
              next_r.sts[i] = ck_ok;
            // A running path keeps going whatever the check says now
            else
              next_r.sts[i] = 1'b1;
          end
        end
        else if (link.addr == REG_RATE_A)
        begin
          next_r.rate_a = link.wdata[RATE_MSB:RATE_LSB];
          rate_chg      = next_r.rate_a != r.rate_a;
        end
        else if (link.addr == REG_RATE_B)
        begin
          next_r.rate_b = link.wdata[RATE_MSB:RATE_LSB];
          rate_chg      = next_r.rate_b != r.rate_b;
        end
        else if (slot[2])
        begin
          next_r.src[slot[1:0]] = link.wdata[7:0];
        end
      end
      else
      begin
        if (link.addr == REG_PATH_EN)
          next_r.rdata = {12'h000, r.en};
        else if (link.addr == REG_PATH_STS)
          next_r.rdata = {12'h000, r.sts};
        else if (link.addr == REG_RATE_A)
          next_r.rdata = {r.rate_a, 11'h000};
        else if (link.addr == REG_RATE_B)
          next_r.rdata = {r.rate_b, 11'h000};
        else if (slot[2])
          next_r.rdata = {8'h00, r.src[slot[1:0]]};
        else
          next_r.rdata = 16'h0000;
      end
    end

    // ----------------------------------------------------------------
    // Lock: restart resync on any rate change or a clock change in a domain that rate A or B uses
    // ----------------------------------------------------------------
    // Counter saturates, so lock holds without wrapping; a stopped path starts over
    for (int i = 0; i < 4; i++)
    begin
      if (!next_r.sts[i] || rate_chg || ref_chg)
        next_r.lock_cnt[i] = '0;
      else if (r.lock_cnt[i] != LOCK_CYC)
        next_r.lock_cnt[i] = r.lock_cnt[i] + 12'h001;
      next_r.lock[i] = next_r.lock_cnt[i] == LOCK_CYC;
    end
    // Registered copy for the pin; a select change shows one cycle later
    next_r.lock_pin = next_r.lock[gpio_lock_sel];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Clock-ok flops clear low, so no path can start before both pins settle
      r        <= '0;
      r.en     <= EN_RST;
      r.rate_a <= RATE_A_RST;
      r.rate_b <= RATE_B_RST;
      r.src    <= {4{SRC_RST}};
    end
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.ack   = r.ack;
  assign link.rdata = r.rdata;
  assign path_run   = r.sts;
  assign path_lock  = r.lock;
  assign lock_gpio  = r.lock_pin;
  assign rate_a_sel = r.rate_a;
  assign rate_b_sel = r.rate_b;
  // Each rate names one domain only; equal domains are allowed
  assign rate_a_dom = arc_rate_dom(r.rate_a);
  assign rate_b_dom = arc_rate_dom(r.rate_b);
  assign path_src   = r.src;

endmodule

// File: hw/arc_ctl.sv
// Configuring controller: AXI4-Lite command registers driving the converter control link
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module arc_ctl
  import arc_pkg::*;
(
  input  wire logic        aclk,    // System clock, 20 MHz
  input  wire logic        aresetn, // Synchronous reset, active low
  arc_link_if.ctl          link,    // Device register access
  input  wire logic [5:0]  awaddr,  // AXI4-Lite write address
  input  wire logic        awvalid, // Write address valid
  output logic             awready, // Write address ready
  input  wire logic [31:0] wdata,   // Write data
  input  wire logic [3:0]  wstrb,   // Write strobes
  input  wire logic        wvalid,  // Write data valid
  output logic             wready,  // Write data ready
  output logic      [1:0]  bresp,   // Write response
  output logic             bvalid,  // Write response valid
  input  wire logic        bready,  // Write response ready
  input  wire logic [5:0]  araddr,  // Read address
  input  wire logic        arvalid, // Read address valid
  output logic             arready, // Read address ready
  output logic      [31:0] rdata,   // Read data
  output logic      [1:0]  rresp,   // Read response
  output logic             rvalid,  // Read data valid
  input  wire logic        rready   // Read data ready
);

  typedef enum logic [1:0] {CS_IDLE, CS_WR, CS_RD} arc_ctl_e;

  typedef struct packed {
    arc_ctl_e    state;
    logic        aw_got;
    logic        w_got;
    logic        wstrb_none;
    logic [5:0]  waddr;
    logic [31:0] wd;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic        l_we;
    logic [15:0] l_addr;
    logic [15:0] l_wdata;
    logic [3:0]  en;
    logic [4:0]  rate_a;
    logic [4:0]  rate_b;
    logic [3:0]  src_nz;
    logic [8:0]  khz_a;
    logic [8:0]  khz_b;
    logic [11:0] wait_cnt;
    logic [3:0]  sts;
    logic        err;
  } arc_ctl_s;

  arc_ctl_s r;
  arc_ctl_s next_r;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        khz_ok;
    logic        rate_ok;
    logic [8:0]  lo;
    logic [8:0]  hi;
    logic [1:0]  path;
    next_r  = r;
    lo      = (r.khz_a < r.khz_b) ? r.khz_a : r.khz_b;
    hi      = (r.khz_a < r.khz_b) ? r.khz_b : r.khz_a;
    path    = r.wd[17:16];
    khz_ok  = (lo >= KHZ_MIN) && (hi <= KHZ_MAX)
              && ({3'h0, hi} <= ({3'h0, lo} * {9'h000, RATIO_MAX}));
    rate_ok = khz_ok && (r.src_nz == 4'h0) && (r.wait_cnt == SRC_WAIT_CYC);

    awready = !r.aw_got && !r.bvalid;
    wready  = !r.w_got && !r.bvalid;
    arready = !r.rvalid;

    if (awvalid && awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.waddr  = awaddr;
    end
    if (wvalid && wready)
    begin
      next_r.w_got      = 1'b1;
      next_r.wd         = wdata;
      // A write with no strobes is answered but changes nothing
      next_r.wstrb_none = wstrb == 4'h0;
    end
    if (bvalid && bready)
      next_r.bvalid = 1'b0;
    if (rvalid && rready)
      next_r.rvalid = 1'b0;

    if (arvalid && arready)
    begin
      next_r.rvalid = 1'b1;
      if (araddr == CTL_ENABLE)
        next_r.rdata = {28'h0000_000, r.en};
      else if (araddr == CTL_RATE_A)
        next_r.rdata = {27'h000_0000, r.rate_a};
      else if (araddr == CTL_RATE_B)
        next_r.rdata = {27'h000_0000, r.rate_b};
      else if (araddr == CTL_SRC)
        next_r.rdata = {28'h0000_000, r.src_nz};
      else if (araddr == CTL_KHZ)
        next_r.rdata = {7'h00, r.khz_b, 7'h00, r.khz_a};
      else if (araddr == CTL_STATUS)
        next_r.rdata = {26'h000_0000, r.state != CS_IDLE, r.err, r.sts};
      else
        next_r.rdata = 32'h0000_0000;
    end

    // The guard time restarts whenever any source is still selected
    if (r.src_nz != 4'h0)
      next_r.wait_cnt = 12'h000;
    else if (r.wait_cnt != SRC_WAIT_CYC)
      next_r.wait_cnt = r.wait_cnt + 12'h001;

    case (r.state)
      CS_IDLE:
      begin
        if (r.aw_got && r.w_got && !r.bvalid)
        begin
          next_r.aw_got = 1'b0;
          next_r.w_got  = 1'b0;
          next_r.bresp  = RESP_OKAY;
          next_r.bvalid = 1'b1;
          next_r.l_we   = 1'b1;
          if (r.wstrb_none)
          begin
          end
          else if (r.waddr == CTL_ENABLE)
          begin
            next_r.en      = r.wd[3:0];
            next_r.l_addr  = REG_PATH_EN;
            next_r.l_wdata = {12'h000, r.wd[3:0]};
            next_r.state   = CS_WR;
            next_r.bvalid  = 1'b0;
          end
          else if ((r.waddr == CTL_RATE_A || r.waddr == CTL_RATE_B) && rate_ok)
          begin
            if (r.waddr == CTL_RATE_A)
              next_r.rate_a = r.wd[4:0];
            else
              next_r.rate_b = r.wd[4:0];
            next_r.l_addr  = (r.waddr == CTL_RATE_A) ? REG_RATE_A : REG_RATE_B;
            next_r.l_wdata = {r.wd[4:0], 11'h000};
            next_r.state   = CS_WR;
            next_r.bvalid  = 1'b0;
          end
          // Forward inputs run at rate A, reverse inputs at rate B
          else if (r.waddr == CTL_SRC
                   && (r.wd[7:0] == 8'h00 || r.wd[12:8] == (path[1] ? r.rate_b : r.rate_a)))
          begin
            next_r.src_nz[path] = r.wd[7:0] != 8'h00;
            next_r.l_addr       = REG_SRC_BASE + {11'h000, path, 3'h0};
            next_r.l_wdata      = {8'h00, r.wd[7:0]};
            next_r.state        = CS_WR;
            next_r.bvalid       = 1'b0;
          end
          else if (r.waddr == CTL_KHZ)
          begin
            next_r.khz_a = r.wd[8:0];
            next_r.khz_b = r.wd[24:16];
          end
          else if (r.waddr == CTL_STATUS)
          begin
            if (r.wd[CTL_ERR_BIT])
              next_r.err = 1'b0;
          end
          else
          begin
            next_r.bresp = RESP_SLVERR;
            next_r.err   = 1'b1;
          end
        end
        else
        begin
          next_r.l_we   = 1'b0;
          next_r.l_addr = REG_PATH_STS;
          next_r.state  = CS_RD;
        end
      end
      CS_WR:
      begin
        if (link.ack)
        begin
          next_r.state  = CS_IDLE;
          next_r.bvalid = 1'b1;
        end
      end
      CS_RD:
      begin
        if (link.ack)
        begin
          next_r.state = CS_IDLE;
          next_r.sts   = link.rdata[3:0];
        end
      end
      default:
        next_r.state = CS_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r        <= '0;
      r.state  <= CS_IDLE;
      r.en     <= EN_RST;
      r.rate_a <= RATE_A_RST;
      r.rate_b <= RATE_B_RST;
    end
    else
      r <= next_r;
  end

  assign link.req   = r.state != CS_IDLE;
  assign link.we    = r.l_we;
  assign link.addr  = r.l_addr;
  assign link.wdata = r.l_wdata;
  assign bresp      = r.bresp;
  assign bvalid     = r.bvalid;
  assign rdata      = r.rdata;
  assign rresp      = RESP_OKAY;
  assign rvalid     = r.rvalid;

endmodule

// File: tb/arc_link_assertions.sv
// Protocol and address checks on the link between the controller and the converter control
`timescale 1ns/100ps
module arc_link_assertions
  import arc_pkg::*;
(
  input wire logic        aclk,    // Shared clock
  input wire logic        aresetn, // Synchronous reset, active low
  input wire logic        req,     // Access request
  input wire logic        we,      // 1 = write
  input wire logic [15:0] addr,    // Device register address
  input wire logic [15:0] wdata,   // Write data
  input wire logic        ack,     // Completion pulse
  input wire logic [15:0] rdata    // Read data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------
  a_ack_follows_req: assert property (req && !ack |=> ack)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a taken request");
  a_req_release: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  a_req_hold: assert property (req && !ack |=> req && $stable(we) && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");

  // ------------------------------------------------------------
  // Register map use
  // ------------------------------------------------------------
  a_src_window: assert property (req && we && addr[15:8] == REG_SRC_BASE[15:8]
    |-> addr >= REG_SRC_BASE && addr <= REG_SRC_LAST && addr[2:0] == 3'h0)
    else $error("source write outside its window");
  a_status_ro: assert property (req && we |-> addr != REG_PATH_STS)
    else $error("write to read-only status");
  a_poll_alive: assert property (!req |-> ##[1:8] req)
    else $error("status polling stalled");

  c_enable_write: cover property (req && we && ack && addr == REG_PATH_EN);
  c_src_write: cover property (req && we && addr == REG_SRC_BASE);
  c_status_read: cover property (req && !we && ack && addr == REG_PATH_STS);
endmodule

// File: tb/async_rate_converter_control_tb.sv
// Testbench driving the controller over AXI4-Lite with the converter control behind the link
`timescale 1ns/100ps
module async_rate_converter_control_tb
  import arc_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, sys_clk_ok = 1'b1, sec_clk_ok = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lock_gpio, rate_a_dom, rate_b_dom;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, r;
  logic [3:0] wstrb = 4'hf, path_run, path_lock;
  logic [1:0] bresp, rresp, gpio_lock_sel = 2'h0;
  logic [4:0] rate_a_sel, rate_b_sel;
  logic [3:0][7:0] path_src;
  int n_mismatch = 0, num_checks = 0;

  always #25 aclk = ~aclk;

  arc_link_if lnk (.aclk(aclk), .aresetn(aresetn));
  arc_dev arc_dev_i (.aclk(aclk), .aresetn(aresetn), .link(lnk), .sys_clk_ok(sys_clk_ok),
    .sec_clk_ok(sec_clk_ok), .gpio_lock_sel(gpio_lock_sel), .path_run(path_run), .path_lock(path_lock),
    .lock_gpio(lock_gpio), .rate_a_sel(rate_a_sel), .rate_b_sel(rate_b_sel), .rate_a_dom(rate_a_dom),
    .rate_b_dom(rate_b_dom), .path_src(path_src));
  arc_ctl arc_ctl_i (.aclk(aclk), .aresetn(aresetn), .link(lnk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  arc_link_assertions arc_link_assertions_i (.aclk(aclk), .aresetn(aresetn), .req(lnk.req), .we(lnk.we),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each channel is released on the edge that takes it; the response waits for both
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga;
    logic gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      ga = ga | awready;
      gw = gw | wready;
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
    end while (!(ga && gw && bvalid));
    bready <= 1'b0;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    logic g;
    g = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      g = g | arready;
      if (g) arvalid <= 1'b0;
    end while (!(g && rvalid));
    rready <= 1'b0;
    d = rdata;
    chk(rresp, RESP_OKAY);
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    cyc(5);
    aresetn <= 1'b1;
    cyc(2);
    chk({rate_b_dom, rate_b_sel, rate_a_sel, path_run, path_lock}, {13'h0, 1'b1, RATE_B_RST, RATE_A_RST, EN_RST, 4'h0});
    wr(CTL_ENABLE, 32'h0000_0003, RESP_OKAY);
    cyc(2);
    chk(path_run, 4'h3);
    chk(path_lock, 4'h0);
    cyc(6);
    rd(CTL_STATUS, r);
    chk(r[4:0], 5'h03);
    cyc(LOCK_CYC + 10);
    chk(path_lock, 4'h3);
    gpio_lock_sel <= 2'h1;
    cyc(3);
    chk(lock_gpio, 1'b1);
    gpio_lock_sel <= 2'h2;
    cyc(3);
    chk(lock_gpio, 1'b0);
    // Secondary clock too slow: locks drop, new paths refused, running ones kept
    sec_clk_ok <= 1'b0;
    cyc(5);
    chk(path_lock, 4'h0);
    wr(CTL_ENABLE, 32'h0000_000f, RESP_OKAY);
    cyc(2);
    chk(path_run, 4'h3);
    sec_clk_ok <= 1'b1;
    cyc(5);
    wr(CTL_ENABLE, 32'h0000_000f, RESP_OKAY);
    cyc(2);
    chk(path_run, 4'hf);
    wr(CTL_ENABLE, 32'h0000_0001, RESP_OKAY);
    cyc(2);
    chk(path_run, 4'h1);
    // Rate change guards
    wr(CTL_KHZ, 32'h0030_0030, RESP_OKAY);
    wr(CTL_SRC, 32'h0000_0010, RESP_OKAY);
    cyc(2);
    chk(path_src[0], 8'h10);
    wr(CTL_SRC, 32'h0002_0010, RESP_SLVERR);
    wr(CTL_RATE_A, 32'h0000_0009, RESP_SLVERR);
    wr(CTL_SRC, 32'h0000_0000, RESP_OKAY);
    wr(CTL_RATE_A, 32'h0000_0009, RESP_SLVERR);
    cyc(SRC_WAIT_CYC);
    wr(CTL_KHZ, 32'h00c0_0008, RESP_OKAY);
    wr(CTL_RATE_A, 32'h0000_0009, RESP_SLVERR);
    wr(CTL_KHZ, 32'h0030_00c8, RESP_OKAY);
    wr(CTL_RATE_A, 32'h0000_0009, RESP_SLVERR);
    wr(CTL_KHZ, 32'h0030_0030, RESP_OKAY);
    wr(CTL_RATE_A, 32'h0000_0009, RESP_OKAY);
    cyc(2);
    chk({rate_a_dom, rate_a_sel, path_lock[0]}, {1'b1, RATE_SEC_2, 1'b0});
    rd(CTL_STATUS, r);
    chk(r[CTL_ERR_BIT], 1'b1);
    wr(CTL_STATUS, 32'h0000_0010, RESP_OKAY);
    cyc(6);
    rd(CTL_STATUS, r);
    chk(r[4:0], 5'h01);
    wr(6'h18, 32'h0000_0001, RESP_SLVERR);
    // Reserved code is stored but fails the check; the running path stays
    wr(CTL_RATE_B, 32'h0000_0005, RESP_OKAY);
    wr(CTL_ENABLE, 32'h0000_0005, RESP_OKAY);
    cyc(2);
    chk({rate_b_sel, path_run}, {5'h05, 4'h1});
    // A write with no byte strobes is answered but must leave the enables alone
    wstrb <= 4'h0;
    wr(CTL_ENABLE, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hf;
    cyc(2);
    chk(path_run, 4'h1);
    final_report();
  end

  // Whole run is about 4700 cycles; this cuts off a hang
  initial
  begin
    cyc(20_000);
    n_mismatch++;
    final_report();
  end
endmodule
